// ---- hdl/sram_port_pkg.sv ----
package sram_port_pkg;

  // ==========================================================
  // Widths
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 21;
  localparam int REG_AW = 8;
  localparam int LOCK_W = 10;
  localparam int GAP_W = 8;
  localparam int IMP_W = 16;

  // ==========================================================
  // Register map
  localparam logic [REG_AW-1:0] CTRL_OFF = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFF = 8'h04;
  localparam logic [REG_AW-1:0] IMP_COUNT_OFF = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_LEGACY_BIT = 1;
  localparam int ST_STOP_BIT = 2;
  localparam int ST_HELD_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Read latency in half cycles of the link clock
  localparam logic [2:0] LAT_PLL = 3'h5;
  localparam logic [2:0] LAT_LEGACY = 3'h2;
  localparam int PIPE_D = 6;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_TIME_NS = 20000;
  localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [LOCK_W-1:0] LOCK_CYC_W = LOCK_W'(LOCK_CYC);
  localparam int STOP_TIME_NS = 30;
  localparam int STOP_RAW = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CYC = (STOP_RAW < 1) ? 1 : STOP_RAW;
  localparam int KGAP_MAX_DEF = 6;
  localparam int IMP_PERIOD_DEF = 1024;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic k;
    logic k_n;
    logic load_n;
    logic rd;
    logic [LANES-1:0] sel_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] dq;
    logic pll_on;
  } pin_in_t;

  // Link clocks reset high so no false rise follows reset
  localparam pin_in_t PIN_RST = '{k: 1'b1, k_n: 1'b1, load_n: 1'b1, sel_n: 2'h3, pll_on: 1'b1,
                                  default: '0};

  typedef struct packed {
    logic v;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
    logic [LANES-1:0] be0_n;
    logic [LANES-1:0] be1_n;
  } held_t;

  typedef struct packed {
    logic v;
    logic [ADDR_W-1:0] addr;
  } rd_stage_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_LO = 2'h1,
    C_HI = 2'h2
  } commit_state_t;

  typedef enum logic [1:0] {
    F_IDLE = 2'h0,
    F_LO = 2'h1,
    F_HI = 2'h2,
    F_CAP = 2'h3
  } fetch_state_t;

endpackage : sram_port_pkg

// ---- hdl/sram_word_array.sv ----
module sram_word_array #(
  parameter int AW = sram_port_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [sram_port_pkg::LANES-1:0] wbe,
  input wire logic [AW-1:0] waddr,
  input wire logic [sram_port_pkg::WORD_W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [sram_port_pkg::WORD_W-1:0] rdata
);
  import sram_port_pkg::*;

  // ==========================================================
  // One array per byte lane, so a lane write leaves the other intact
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [0:(1<<AW)-1];
      logic [LANE_W-1:0] lane_q;
      always_ff @(posedge clk) begin
        if (we && wbe[g]) begin
          lane_mem[waddr] <= wdata[g*LANE_W +: LANE_W];
        end
        lane_q <= lane_mem[raddr];
      end
      assign rdata[g*LANE_W +: LANE_W] = lane_q;
    end
  endgenerate

endmodule : sram_word_array

// ---- hdl/burst_sram_port.sv ----
// Contract
// - Byte selects sampled with each data word
// - Selected bytes of write data stored
// - Low select writes [8:0], high [17:9]
// - Write before reads held in registers
// - Held write committed on next write
// - Read of held address returns newest data
// - Impedance update every 1024 clock cycles
// - Two free-running echo clocks follow inputs
// - Valid flag leads read data by half cycle
// - PLL locks after 20 us stable clock
// - Clock stopped 30 ns resets PLL
// - PLL disable low selects legacy mode
// - Write: load low, select low, data next
// - Read: data pair 2.5 cycles later
// - Stopped clock holds data pins
// - Reset comes up deselected, pins released
// - Burst accesses A then A+1
// - Legacy mode read latency one cycle
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module burst_sram_port #(
  parameter int KGAP_MAX = sram_port_pkg::KGAP_MAX_DEF,
  parameter int IMP_PERIOD = sram_port_pkg::IMP_PERIOD_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sram_port_pkg::REG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sram_port_pkg::REG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [sram_port_pkg::LANES-1:0] byte_write_select_n,
  input wire logic [sram_port_pkg::ADDR_W-1:0] addr,
  input wire logic [sram_port_pkg::WORD_W-1:0] dq_i,
  output logic [sram_port_pkg::WORD_W-1:0] dq_o,
  output logic dq_oe_n,
  output logic echo_clock,
  output logic echo_clock_n,
  output logic read_valid_flag,
  input wire logic pll_disable_n,
  output logic imp_update
);
  import sram_port_pkg::*;

  pin_in_t pin_raw;
  pin_in_t pin_s1_q;
  pin_in_t pin_s2_q;
  logic k_prev_q;
  logic kn_prev_q;
  logic k_rise;
  logic kn_rise;
  logic half_edge;
  logic he_d_q;
  logic [GAP_W-1:0] gap_q;
  logic clk_stopped;
  logic legacy;
  logic [LOCK_W-1:0] lock_cnt_q;
  logic pll_locked_q;
  logic ctrl_en_q;
  logic cmd_ok;
  logic issue_rd;
  logic issue_wr;
  logic [2:0] lat;
  rd_stage_t rd_q [PIPE_D];
  rd_stage_t wr_cmd_q;
  logic wr_w1_q;
  held_t held_q;
  held_t commit_q;
  commit_state_t c_state_q;
  fetch_state_t f_state_q;
  logic [ADDR_W-1:0] fa_q;
  logic [WORD_W-1:0] fw0_q;
  logic [WORD_W-1:0] fw1_q;
  logic [WORD_W-1:0] w1_stage_q;
  logic drive0;
  logic drive1;
  logic mem_we;
  logic [LANES-1:0] mem_wbe;
  logic [ADDR_W-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;
  logic [WORD_W-1:0] mem_rdata;
  logic [IMP_W-1:0] imp_div_q;
  logic [31:0] imp_count_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [REG_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ==========================================================
  // Functions
  // Overlay newest held bytes on a word fetched from the array
  function automatic logic [WORD_W-1:0] merge_held(input logic [WORD_W-1:0] w,
      input logic [ADDR_W-1:0] a, input held_t h);
    logic [WORD_W-1:0] r;
    logic [WORD_W-1:0] src;
    logic [LANES-1:0] sel;
    r = w;
    src = h.w1;
    sel = '0;
    if (h.v && a == h.addr) begin
      src = h.w0;
      sel = ~h.be0_n;
    end else if (h.v && a == h.addr + 1'b1) begin
      sel = ~h.be1_n;
    end
    for (int i = 0; i < LANES; i++) begin
      if (sel[i]) begin
        r[i*LANE_W +: LANE_W] = src[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction : merge_held

  function automatic logic reg_mapped(input logic [REG_AW-1:0] a);
    return (a == CTRL_OFF) || (a == STATUS_OFF) || (a == IMP_COUNT_OFF);
  endfunction : reg_mapped

  // ==========================================================
  // Pin synchronisers and link clock edges
  assign pin_raw = '{k: k, k_n: k_n, load_n: load_strobe_n, rd: read_not_write,
                     sel_n: byte_write_select_n, addr: addr, dq: dq_i,
                     pll_on: pll_disable_n};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      k_prev_q <= 1'b1;
      kn_prev_q <= 1'b1;
      he_d_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      k_prev_q <= pin_s2_q.k;
      kn_prev_q <= pin_s2_q.k_n;
      he_d_q <= half_edge;
    end
  end

  assign k_rise = pin_s2_q.k & ~k_prev_q;
  assign kn_rise = pin_s2_q.k_n & ~kn_prev_q;
  assign half_edge = k_rise | kn_rise;
  assign legacy = ~pin_s2_q.pll_on;
  assign lat = legacy ? LAT_LEGACY : LAT_PLL;

  // ==========================================================
  // Clock watchdog and PLL lock model
  // Gap counter saturates, so a long stop cannot wrap into a run
  always_ff @(posedge aclk) begin
    if (!aresetn || half_edge) begin
      gap_q <= '0;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  assign clk_stopped = gap_q > GAP_W'(KGAP_MAX + STOP_CYC);

  always_ff @(posedge aclk) begin
    if (!aresetn || legacy || clk_stopped) begin
      lock_cnt_q <= '0;
      pll_locked_q <= 1'b0;
    end else if (lock_cnt_q == LOCK_CYC_W) begin
      pll_locked_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Command decode at the primary rise
  assign cmd_ok = ctrl_en_q & (legacy | pll_locked_q);
  assign issue_rd = k_rise & cmd_ok & ~pin_s2_q.load_n & pin_s2_q.rd;
  assign issue_wr = k_rise & cmd_ok & ~pin_s2_q.load_n & ~pin_s2_q.rd;

  // Read pipeline, one stage per half cycle of the link clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PIPE_D; i++) begin
        rd_q[i] <= '0;
      end
    end else if (half_edge) begin
      rd_q[0] <= issue_rd ? rd_stage_t'{v: 1'b1, addr: pin_s2_q.addr} : '0;
      for (int i = 1; i < PIPE_D; i++) begin
        rd_q[i] <= rd_q[i-1];
      end
    end
  end

  // ==========================================================
  // Write capture and posted write register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_cmd_q <= '0;
      wr_w1_q <= 1'b0;
    end else begin
      if (k_rise) begin
        wr_cmd_q <= issue_wr ? rd_stage_t'{v: 1'b1, addr: pin_s2_q.addr} : '0;
        wr_w1_q <= wr_cmd_q.v;
      end else if (kn_rise) begin
        wr_w1_q <= 1'b0;
      end
    end
  end

  // Last write stays here until the next write arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= '0;
    end else if (k_rise && wr_cmd_q.v) begin
      held_q <= '{v: 1'b1, addr: wr_cmd_q.addr, w0: pin_s2_q.dq,
                  be0_n: pin_s2_q.sel_n, w1: '0, be1_n: '1};
    end else if (kn_rise && wr_w1_q) begin
      held_q.w1 <= pin_s2_q.dq;
      held_q.be1_n <= pin_s2_q.sel_n;
    end
  end

  // Commit of the older held write, word A then A+1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_state_q <= C_IDLE;
      commit_q <= '0;
    end else begin
      case (c_state_q)
        C_IDLE: begin
          if (k_rise && wr_cmd_q.v && held_q.v) begin
            commit_q <= held_q;
            c_state_q <= C_LO;
          end
        end
        C_LO: c_state_q <= C_HI;
        C_HI: c_state_q <= C_IDLE;
        default: c_state_q <= C_IDLE;
      endcase
    end
  end

  assign mem_we = (c_state_q == C_LO) || (c_state_q == C_HI);
  assign mem_waddr = (c_state_q == C_HI) ? commit_q.addr + 1'b1 : commit_q.addr;
  assign mem_wdata = (c_state_q == C_HI) ? commit_q.w1 : commit_q.w0;
  assign mem_wbe = (c_state_q == C_HI) ? ~commit_q.be1_n : ~commit_q.be0_n;

  // ==========================================================
  // Array fetch; starts the cycle after the edge, so its first read sees a same-edge commit's word A but not A+1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f_state_q <= F_IDLE;
      fa_q <= '0;
      fw0_q <= '0;
      fw1_q <= '0;
    end else begin
      case (f_state_q)
        F_IDLE: begin
          if (he_d_q && rd_q[lat-3'h2].v) begin
            fa_q <= rd_q[lat-3'h2].addr;
            f_state_q <= F_LO;
          end
        end
        F_LO: f_state_q <= F_HI;
        F_HI: begin
          fw0_q <= mem_rdata;
          f_state_q <= F_CAP;
        end
        F_CAP: begin
          fw1_q <= mem_rdata;
          f_state_q <= F_IDLE;
        end
        default: f_state_q <= F_IDLE;
      endcase
    end
  end

  assign mem_raddr = (f_state_q == F_HI) ? fa_q + 1'b1 : fa_q;

  sram_word_array #(
    .AW(ADDR_W)
  ) u_array (
    .clk(aclk),
    .we(mem_we),
    .wbe(mem_wbe),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Data pins; nothing moves between link edges, so a stopped clock holds
  assign drive0 = rd_q[lat-3'h1].v;
  assign drive1 = rd_q[lat].v;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_o <= '0;
      dq_oe_n <= 1'b1;
      read_valid_flag <= 1'b0;
      w1_stage_q <= '0;
    end else if (half_edge) begin
      if (drive0) begin
        dq_o <= merge_held(fw0_q, rd_q[lat-3'h1].addr, held_q);
        w1_stage_q <= fw1_q;
      end else if (drive1) begin
        dq_o <= merge_held(w1_stage_q, rd_q[lat].addr + 1'b1, held_q);
      end
      dq_oe_n <= ~(drive0 | drive1);
      read_valid_flag <= rd_q[lat-3'h2].v | drive0;
    end
  end

  // ==========================================================
  // Echo clocks, registered copies of the sampled inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      echo_clock <= 1'b0;
      echo_clock_n <= 1'b0;
    end else begin
      echo_clock <= pin_s2_q.k;
      echo_clock_n <= pin_s2_q.k_n;
    end
  end

  // ==========================================================
  // Periodic impedance update, counted in link clock cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imp_div_q <= '0;
      imp_update <= 1'b0;
      imp_count_q <= '0;
    end else begin
      imp_update <= 1'b0;
      if (k_rise) begin
        if (imp_div_q == IMP_W'(IMP_PERIOD - 1)) begin
          imp_div_q <= '0;
          imp_update <= 1'b1;
          imp_count_q <= imp_count_q + 1'b1;
        end else begin
          imp_div_q <= imp_div_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Register bus: write channel, address and data in either order
  assign awready = ~aw_hold_q & ~bvalid;
  assign wready = ~w_hold_q & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control register; gates new commands, pending bursts still finish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_q <= CTRL_EN_RST;
    end else if (aw_hold_q && w_hold_q && awaddr_q == CTRL_OFF && wstrb_q[0]) begin
      ctrl_en_q <= wdata_q[CTRL_EN_BIT];
    end
  end

  // Read channel, answer one cycle after the address
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= '0;
      case (araddr)
        CTRL_OFF: rdata[CTRL_EN_BIT] <= ctrl_en_q;
        STATUS_OFF: begin
          rdata[ST_LOCK_BIT] <= pll_locked_q;
          rdata[ST_LEGACY_BIT] <= legacy;
          rdata[ST_STOP_BIT] <= clk_stopped;
          rdata[ST_HELD_BIT] <= held_q.v;
        end
        IMP_COUNT_OFF: rdata <= imp_count_q;
        default: rdata <= '0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_hiz;
    $rose(aresetn) |-> dq_oe_n && !read_valid_flag;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins not released after reset");

  property p_nop_hiz;
    half_edge && !drive0 && !drive1 |=> dq_oe_n;
  endproperty
  a_nop_hiz: assert property (p_nop_hiz) else $error("data pins driven when idle");

  property p_valid_lead;
    $fell(dq_oe_n) |-> $past(read_valid_flag) && read_valid_flag;
  endproperty
  a_valid_lead: assert property (p_valid_lead) else $error("valid flag not ahead of data");

  property p_drive_lat;
    half_edge && drive0 |=> !dq_oe_n && dq_o == merge_held(fw0_q, $past(rd_q[lat-3'h1].addr), $past(held_q));
  endproperty
  a_drive_lat: assert property (p_drive_lat) else $error("read word not driven on time");

  property p_echo;
    k_rise |-> !echo_clock ##1 echo_clock;
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock not following input");

  property p_commit_seq;
    c_state_q == C_IDLE && k_rise && wr_cmd_q.v && held_q.v
      |=> c_state_q == C_LO && mem_waddr == $past(held_q.addr) ##1
          c_state_q == C_HI && mem_waddr == $past(held_q.addr, 2) + 1'b1;
  endproperty
  a_commit_seq: assert property (p_commit_seq) else $error("held write not committed");

  property p_commit_mask;
    c_state_q == C_LO |-> mem_wbe == ~commit_q.be0_n && mem_wdata == commit_q.w0;
  endproperty
  a_commit_mask: assert property (p_commit_mask) else $error("byte lanes written wrongly");

  property p_imp;
    k_rise && imp_div_q == IMP_W'(IMP_PERIOD - 1) |=> imp_update ##1 !imp_update;
  endproperty
  a_imp: assert property (p_imp) else $error("impedance update missed");

  property p_lock;
    $rose(pll_locked_q) |-> lock_cnt_q == LOCK_CYC_W && !legacy;
  endproperty
  a_lock: assert property (p_lock) else $error("lock before stable time");

  property p_stop;
    clk_stopped || legacy |=> !pll_locked_q;
  endproperty
  a_stop: assert property (p_stop) else $error("lock kept with clock stopped");

  c_pll_read: cover property (half_edge && drive0 && !legacy);
  c_legacy_read: cover property (half_edge && drive0 && legacy);
  c_commit: cover property (c_state_q == C_HI && commit_q.be1_n != commit_q.be0_n);
  c_bypass: cover property (half_edge && drive0 && held_q.v && rd_q[lat-3'h1].addr == held_q.addr);

endmodule : burst_sram_port

// ---- bench/link_ctrl_model.sv ----
module link_ctrl_model #(
  parameter int NOP_RW = 2
) (
  output logic k,
  output logic k_n,
  output logic load_strobe_n,
  output logic read_not_write,
  output logic [sram_port_pkg::LANES-1:0] byte_write_select_n,
  output logic [sram_port_pkg::ADDR_W-1:0] addr,
  output logic [sram_port_pkg::WORD_W-1:0] dq_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;

  logic rd_last;

  // ========================================
  // Link clocks, free running, phase unrelated to aclk
  assign k_n = ~k;
  initial begin
    k = 1'b0;
    load_strobe_n = 1'b1;
    read_not_write = 1'b1;
    byte_write_select_n = 2'h3;
    addr = '0;
    dq_i = '0;
    rd_last = 1'b0;
    #7;
    forever #160 k = ~k;
  end

  // ========================================
  // Command set a quarter period before k rise, kept a quarter after
  task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a);
    @(negedge k);
    #80;
    load_strobe_n = 1'b0;
    read_not_write = rd;
    addr = a;
    @(posedge k);
    #80;
    load_strobe_n = 1'b1;
    read_not_write = ~rd;
    addr = ~a; // Released lines flip so stale values never match
  endtask : cmd

  // Write burst: words on next k rise and k_n rise
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d0, d1,
      input logic [LANES-1:0] s0, s1);
    if (rd_last) repeat (NOP_RW) @(posedge k);
    rd_last = 1'b0;
    cmd(1'b0, a);
    @(negedge k);
    #80;
    dq_i = d0;
    byte_write_select_n = s0;
    @(posedge k);
    #80;
    dq_i = d1;
    byte_write_select_n = s1;
    @(negedge k);
    #80;
    dq_i = ~d1;
    byte_write_select_n = ~s1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    rd_last = 1'b1;
    cmd(1'b1, a);
  endtask : rd
endmodule : link_ctrl_model

// ---- bench/ddr_two_word_burst_sram_port_test.sv ----
module ddr_two_word_burst_sram_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_port_pkg::*;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, k, k_n, load_strobe_n, read_not_write;
  logic dq_oe_n, echo_clock, echo_clock_n, read_valid_flag, pll_disable_n, imp_update, ep;
  logic [REG_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [LANES-1:0] byte_write_select_n;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] dq_i, dq_o;
  logic [WORD_W-1:0] mem [int];
  logic [WORD_W-1:0] wq [$];
  logic [65:0] rq [$];
  logic [65:0] e;
  logic [1:0] bq [$];
  realtime tq [$];
  realtime tv;
  int fail_count, checks_done, seed, lat, gap, imps, ecnt, n0;

  burst_sram_port #(.IMP_PERIOD(8)) i_burst_sram_port (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .k, .k_n, .load_strobe_n, .read_not_write, .byte_write_select_n, .addr,
    .dq_i, .dq_o, .dq_oe_n, .echo_clock, .echo_clock_n, .read_valid_flag,
    .pll_disable_n, .imp_update
  );
  link_ctrl_model i_link_ctrl_model (
    .k, .k_n, .load_strobe_n, .read_not_write, .byte_write_select_n, .addr, .dq_i
  );

  // ========================================
  // Checking helpers
  task automatic results();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected %0t %s", $realtime, m);
    end
  endtask : chk

  function automatic logic [WORD_W-1:0] rnd();
    return WORD_W'($random(seed));
  endfunction : rnd

  // Lane merge, a high select keeps the old lane
  function automatic logic [WORD_W-1:0] mrg(input logic [WORD_W-1:0] o, n,
      input logic [LANES-1:0] s);
    return {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
  endfunction : mrg

  // ========================================
  // Register bus master, waits bounded
  task automatic axw(input logic [REG_AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      n++;
    end while (bready && n < 50);
    if (n >= 50) begin
      chk(1'b0, "write timeout");
      results();
    end
  endtask : axw

  task automatic axr(input logic [REG_AW-1:0] a, input logic [31:0] m, d,
      input logic [1:0] r);
    int n;
    rq.push_back({r, m, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
      n++;
    end while (rready && n < 50);
    if (n >= 50) begin
      chk(1'b0, "read timeout");
      results();
    end
  endtask : axr

  // ========================================
  // Link traffic, expectations noted in queues
  task automatic lw(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d0, d1,
      input logic [LANES-1:0] s0, s1, input logic u);
    i_link_ctrl_model.wr(a, d0, d1, s0, s1);
    if (u) begin
      mem[a] = mrg(mem.exists(a) ? mem[a] : d0, d0, s0);
      mem[a + 1] = mrg(mem.exists(a + 1) ? mem[a + 1] : d1, d1, s1);
    end
  endtask : lw

  task automatic lr(input logic [ADDR_W-1:0] a, input logic x);
    i_link_ctrl_model.rd(a);
    if (x) begin
      tq.push_back($realtime + lat * 160 - 80); // Model returns 80 ns past k rise
      wq.push_back(mem[a]);
      wq.push_back(mem[a + 1]);
    end
    repeat (48) @(posedge aclk);
  endtask : lr

  // ========================================
  // Watchers: bus answers, read bursts, update pulses
  always @(posedge aclk) begin
    if (bvalid && bready) chk(bq.size() > 0 && bresp === bq.pop_front(), "write resp");
    if (rvalid && rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk({rresp, rdata & e[63:32]} === {e[65:64], e[31:0]}, "register read");
    end
    ep <= echo_clock;
    if (echo_clock && !ep) ecnt <= ecnt + 1;
    gap <= imp_update ? 0 : gap + 1;
    if (imp_update && imps > 0) chk(gap >= 62 && gap <= 64, "update spacing");
    if (imp_update) imps <= imps + 1;
  end

  always @(posedge read_valid_flag) tv = $realtime;

  // Sampled mid-word since link edges land with one aclk of jitter
  initial begin
    forever begin
      @(negedge dq_oe_n);
      if (wq.size() < 2) begin
        chk(1'b0, "data pins driven without a read");
      end else begin
        chk($realtime >= tq[0] + 80 && $realtime <= tq[0] + 240, "latency");
        void'(tq.pop_front());
        chk($realtime - tv >= 120 && $realtime - tv <= 200, "valid lead");
        repeat (2) @(posedge aclk);
        chk(dq_o === wq.pop_front(), "first word");
        repeat (4) @(posedge aclk);
        chk(dq_o === wq.pop_front(), "second word");
        repeat (4) @(posedge aclk);
        chk(dq_oe_n === 1'b1, "pins not released");
      end
    end
  end

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge aclk);
    chk(1'b0, "run timeout");
    results();
  end

  // ========================================
  // Main sequence
  initial begin
    seed = 32'h765D;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    pll_disable_n = 1'b1;
    lat = LAT_PLL;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(dq_oe_n === 1'b1 && read_valid_flag === 1'b0, "reset pins");
    axr(CTRL_OFF, 32'h1, 32'h1, RESP_OKAY);
    axw(8'h40, 32'h0, RESP_SLVERR);
    axr(8'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    n0 = ecnt;
    repeat (600) @(posedge aclk);
    chk(ecnt - n0 >= 74 && ecnt - n0 <= 76, "echo rate");
    chk(echo_clock_n === ~echo_clock, "echo pair");
    axr(STATUS_OFF, 32'hF, 32'h1, RESP_OKAY);
    // Read the update count right after a pulse, so none lands mid-read
    repeat (70) if (!imp_update) @(posedge aclk);
    if (!imp_update) begin
      chk(1'b0, "no update pulse");
      results();
    end
    axr(IMP_COUNT_OFF, 32'hFFFFFFFF, 32'(imps + 1), RESP_OKAY);
    for (int i = 0; i < 4; i++) lw(ADDR_W'(2 * i), rnd(), rnd(), 2'h0, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lw(ADDR_W'(2 * i), rnd(), rnd(), 2'(i), ~2'(i), 1'b1);
      lr(ADDR_W'(2 * i), 1'b1);
    end
    lw(21'h100, rnd(), rnd(), 2'h0, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++) lr(ADDR_W'(2 * i), 1'b1);
    // Commands while disabled change nothing
    axw(CTRL_OFF, 32'h0, RESP_OKAY);
    lw(21'h0, rnd(), rnd(), 2'h0, 2'h0, 1'b0);
    lr(21'h0, 1'b0);
    axw(CTRL_OFF, 32'h1, RESP_OKAY);
    lr(21'h0, 1'b1);
    pll_disable_n <= 1'b0;
    lat = LAT_LEGACY;
    repeat (20) @(posedge aclk);
    axr(STATUS_OFF, 32'h2, 32'h2, RESP_OKAY);
    lw(21'h10, rnd(), rnd(), 2'h0, 2'h0, 1'b1);
    lr(21'h10, 1'b1);
    lw(21'h10, rnd(), rnd(), 2'h2, 2'h1, 1'b1);
    lr(21'h100, 1'b1);
    lr(21'h10, 1'b1);
    chk(imps > 2 && wq.size() == 0, "pending work");
    results();
  end
endmodule : ddr_two_word_burst_sram_port_test
